// [prrm_defines.svh]
`ifndef PRRM_DEFINES_SVH
`define PRRM_DEFINES_SVH

// ----------------------------------------------------------------------
// Register count and data width
// ----------------------------------------------------------------------
`define PRRM_NUM_REGS         15
`define PRRM_DATA_W           16

// ----------------------------------------------------------------------
// Standard I/O-space map
// ----------------------------------------------------------------------
`define PRRM_ADDR_PMS         16'hffe4
`define PRRM_ADDR_CLKPIN      16'hffe8
`define PRRM_ADDR_SSDATA      16'hfff0
`define PRRM_ADDR_SSCTL       16'hfff1
`define PRRM_ADDR_SSSTAT      16'hfff2
`define PRRM_ADDR_SSMC        16'hfff3
`define PRRM_ADDR_ASDATA      16'hfff4
`define PRRM_ADDR_ASCTL       16'hfff5
`define PRRM_ADDR_PINSTAT     16'hfff6
`define PRRM_ADDR_BAUD        16'hfff7
`define PRRM_ADDR_CDCTL       16'hfff8
`define PRRM_ADDR_PERIOD      16'hfff9
`define PRRM_ADDR_COUNT       16'hfffa
`define PRRM_ADDR_SSCNT       16'hfffb
`define PRRM_ADDR_WAIT        16'hfffc

// ----------------------------------------------------------------------
// Reduced I/O-space map
// ----------------------------------------------------------------------
`define PRRM_RADDR_CDCTL      16'hfffc
`define PRRM_RADDR_PERIOD     16'hfffd
`define PRRM_RADDR_COUNT      16'hfffe
`define PRRM_RADDR_WAIT       16'hffff

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PRRM_RST_PMS          16'h000c
`define PRRM_RST_CLKPIN       16'h0000
`define PRRM_RST_DATA         16'h0000
`define PRRM_RST_SSCTL        16'h0030
`define PRRM_RST_SSSTAT       16'h0000
`define PRRM_RST_SSMC         16'h0000
`define PRRM_RST_ASCTL        16'h0000
`define PRRM_RST_PINSTAT      16'h1800
`define PRRM_RST_BAUD         16'h0001
`define PRRM_RST_CDCTL        16'h0000
`define PRRM_RST_PERIOD       16'hffff
`define PRRM_RST_COUNT        16'hffff
`define PRRM_RST_SSCNT        16'h0000
`define PRRM_RST_WAIT         16'h0fff

// ----------------------------------------------------------------------
// Write masks and field positions
// ----------------------------------------------------------------------
`define PRRM_WMASK_ALL        16'hffff
`define PRRM_WMASK_PMS        16'h000c
`define PRRM_WMASK_CLKPIN     16'h0001
`define PRRM_WMASK_PINSTAT    16'hff00
`define PRRM_PMS_BOOT_BIT     0
`define PRRM_PMS_LEVEL_BIT    1
`define PRRM_CLKPIN_OFF_BIT   0
`define PRRM_ASCTL_DIR_LSB    8
`define PRRM_PINSTAT_PIN_LSB  0

`endif

// [prrm_pkg.sv]
`default_nettype none
package prrm_pkg;

  typedef logic [15:0] prrm_word_t;

  typedef enum {
    prrm_idx_pms,
    prrm_idx_clkpin,
    prrm_idx_ssdata,
    prrm_idx_ssctl,
    prrm_idx_ssstat,
    prrm_idx_ssmc,
    prrm_idx_asdata,
    prrm_idx_asctl,
    prrm_idx_pinstat,
    prrm_idx_baud,
    prrm_idx_cdctl,
    prrm_idx_period,
    prrm_idx_count,
    prrm_idx_sscnt,
    prrm_idx_wait
  } prrm_reg_idx_t;

endpackage : prrm_pkg
`default_nettype wire

// [prrm_reg16.sv]
`timescale 1ns/10ps
`default_nettype none
module prrm_reg16 #(
  parameter logic [15:0] RESET_CONST = 16'h0000,
  parameter logic [15:0] WRITE_MASK  = 16'hffff,
  parameter bit          HAS_RESET   = 1'b1
) (
  input  wire logic        clk,          // core clock
  input  wire logic        rst_n,        // synchronised async reset
  input  wire logic        load_reset,   // peripheral reset active
  input  wire logic [15:0] reset_value,  // value loaded under reset
  input  wire logic        write_en,     // CPU write to this register
  input  wire logic [15:0] write_data,   // CPU write data
  output var  logic [15:0] q             // register contents
);

  wire [15:0] next_q = (q & ~WRITE_MASK) | (write_data & WRITE_MASK);

  generate
    if (HAS_RESET)
    begin : g_rst
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          q <= RESET_CONST;
        else if (load_reset)
          q <= reset_value;
        else if (write_en)
          q <= next_q;
      end
    end
    else
    begin : g_norst
      // Data holding registers carry no reset; their value is undefined.
      always_ff @(posedge clk)
      begin
        if (write_en)
          q <= next_q;
      end
    end
  endgenerate

endmodule : prrm_reg16
`default_nettype wire

// [prrm_reset_ctl.sv]
`timescale 1ns/10ps
`default_nettype none
module prrm_reset_ctl (
  input  wire logic clk,             // core clock
  input  wire logic reset_n,         // async device reset, active low
  input  wire logic soft_reset_req,  // CPU request for peripheral reset
  output var  logic rst_sync_n,      // synchronised reset, active low
  output var  logic periph_reset_n   // peripheral reset line, active low
);

  logic rst_meta_n;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // The line stays asserted one edge past release so pins are captured.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      periph_reset_n <= 1'b0;
    else
      periph_reset_n <= rst_sync_n & ~soft_reset_req;
  end

endmodule : prrm_reset_ctl
`default_nettype wire

// [prrm_top.sv]
// Summary of operation
// - Peripheral control and data registers live in I/O space.
// - Any reset drives peripheral reset to all registers except the two serial data registers.
// - Memory status resets 000x, pin bits from pins.
// - Clock-pin control resets 0000, clock pin driven.
// - Serial data registers are not reset.
// - Sync control resets to 0030h.
// - Same value: external clocks, continuous, both enabled.
// - Sync status resets to 0000h.
// - Sync multichannel resets to 0000h.
// - Async control resets to 0000h.
// - Transmit pin high, aux pins inputs.
// - Pin status resets 180xh, low four bits pins.
// - Baud divisor resets to 0001h.
// - Countdown control resets to 0000h.
// - Reload period resets to FFFFh.
// - Counter value resets to FFFFh.
// - Sync serial counter resets to 0000h.
// - Wait-state control resets to 0FFFh.
// - Reduced map: timer and wait at FFFCh-FFFFh.
`timescale 1ns/10ps
`default_nettype none
`include "prrm_defines.svh"
module prrm_top (
  input  wire logic        clk,                   // core clock, 125 MHz
  input  wire logic        reset_n,               // device reset
  input  wire logic        soft_reset_req,        // CPU peripheral reset
  input  wire logic        reduced_map_pin,       // reduced variant strap
  input  wire logic        boot_memory_select,    // boot select pin
  input  wire logic        external_level_bit,    // external level pin
  input  wire logic [3:0]  aux_pin_in,            // aux pins 3..0 level
  input  wire logic        io_strobe,             // I/O-space cycle
  input  wire logic        io_write,              // write cycle
  input  wire logic        io_read,               // read cycle
  input  wire logic [15:0] io_addr,               // I/O address
  input  wire logic [15:0] io_wdata,              // write data
  output var  logic [15:0] io_rdata,              // read data
  output var  logic        io_ack,                // cycle answered
  output var  logic        peripheral_reset_line_n, // peripheral reset
  output var  logic        core_clock_output_off, // clock pin disabled
  output var  logic        async_tx_out,          // async transmit pin
  output var  logic [3:0]  aux_pin_out,           // aux pin drive level
  output var  logic [3:0]  aux_pin_oe_n,          // aux pin enable
  output var  logic [15:0] sync_serial_control,   // sync control
  output var  logic [15:0] sync_serial_status,    // sync status
  output var  logic [15:0] sync_serial_multichannel, // sync multichannel
  output var  logic [15:0] async_serial_control,  // async control
  output var  logic [15:0] baud_divisor,          // baud divisor
  output var  logic [15:0] countdown_control,     // timer control
  output var  logic [15:0] reload_period,         // timer period
  output var  logic [15:0] down_counter_value,    // timer count
  output var  logic [15:0] wait_state_control     // wait states
);

  // --------------------------------------------------------------------
  // Register tables
  // --------------------------------------------------------------------
  localparam int N = `PRRM_NUM_REGS;

  localparam logic [15:0] STD_ADDR [N] = '{
    `PRRM_ADDR_PMS, `PRRM_ADDR_CLKPIN, `PRRM_ADDR_SSDATA,
    `PRRM_ADDR_SSCTL, `PRRM_ADDR_SSSTAT, `PRRM_ADDR_SSMC,
    `PRRM_ADDR_ASDATA, `PRRM_ADDR_ASCTL, `PRRM_ADDR_PINSTAT,
    `PRRM_ADDR_BAUD, `PRRM_ADDR_CDCTL, `PRRM_ADDR_PERIOD,
    `PRRM_ADDR_COUNT, `PRRM_ADDR_SSCNT, `PRRM_ADDR_WAIT
  };

  // Unused slots of the reduced map never match: their valid bit is 0.
  localparam logic [15:0] RED_ADDR [N] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000,
    `PRRM_RADDR_CDCTL, `PRRM_RADDR_PERIOD, `PRRM_RADDR_COUNT,
    16'h0000, `PRRM_RADDR_WAIT
  };

  localparam logic [N-1:0] RED_VALID = 15'h5c00;

  localparam logic [15:0] RST_TAB [N] = '{
    `PRRM_RST_PMS, `PRRM_RST_CLKPIN, `PRRM_RST_DATA,
    `PRRM_RST_SSCTL, `PRRM_RST_SSSTAT, `PRRM_RST_SSMC,
    `PRRM_RST_DATA, `PRRM_RST_ASCTL, `PRRM_RST_PINSTAT,
    `PRRM_RST_BAUD, `PRRM_RST_CDCTL, `PRRM_RST_PERIOD,
    `PRRM_RST_COUNT, `PRRM_RST_SSCNT, `PRRM_RST_WAIT
  };

  localparam logic [15:0] WMASK_TAB [N] = '{
    `PRRM_WMASK_PMS, `PRRM_WMASK_CLKPIN, `PRRM_WMASK_ALL,
    `PRRM_WMASK_ALL, `PRRM_WMASK_ALL, `PRRM_WMASK_ALL,
    `PRRM_WMASK_ALL, `PRRM_WMASK_ALL, `PRRM_WMASK_PINSTAT,
    `PRRM_WMASK_ALL, `PRRM_WMASK_ALL, `PRRM_WMASK_ALL,
    `PRRM_WMASK_ALL, `PRRM_WMASK_ALL, `PRRM_WMASK_ALL
  };

  localparam logic [N-1:0] HAS_RST = 15'h7fbb;

  localparam int I_PMS     = int'(prrm_pkg::prrm_idx_pms);
  localparam int I_CLKPIN  = int'(prrm_pkg::prrm_idx_clkpin);
  localparam int I_SSDATA  = int'(prrm_pkg::prrm_idx_ssdata);
  localparam int I_SSCTL   = int'(prrm_pkg::prrm_idx_ssctl);
  localparam int I_SSSTAT  = int'(prrm_pkg::prrm_idx_ssstat);
  localparam int I_SSMC    = int'(prrm_pkg::prrm_idx_ssmc);
  localparam int I_ASDATA  = int'(prrm_pkg::prrm_idx_asdata);
  localparam int I_ASCTL   = int'(prrm_pkg::prrm_idx_asctl);
  localparam int I_PINSTAT = int'(prrm_pkg::prrm_idx_pinstat);
  localparam int I_BAUD    = int'(prrm_pkg::prrm_idx_baud);
  localparam int I_CDCTL   = int'(prrm_pkg::prrm_idx_cdctl);
  localparam int I_PERIOD  = int'(prrm_pkg::prrm_idx_period);
  localparam int I_COUNT   = int'(prrm_pkg::prrm_idx_count);
  localparam int I_SSCNT   = int'(prrm_pkg::prrm_idx_sscnt);
  localparam int I_WAIT    = int'(prrm_pkg::prrm_idx_wait);

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  function automatic logic [N-1:0] prrm_decode(
    input logic [15:0] addr,
    input logic        reduced
  );
    logic [N-1:0] hit;
    hit = '0;
    for (int i = 0; i < N; i++)
    begin
      if (reduced)
        hit[i] = RED_VALID[i] && (addr == RED_ADDR[i]);
      else
        hit[i] = (addr == STD_ADDR[i]);
    end
    return hit;
  endfunction : prrm_decode

  // --------------------------------------------------------------------
  // Reset generation
  // --------------------------------------------------------------------
  logic rst_sync_n;

  prrm_reset_ctl u_reset_ctl (
    .clk            (clk),
    .reset_n        (reset_n),
    .soft_reset_req (soft_reset_req),
    .rst_sync_n     (rst_sync_n),
    .periph_reset_n (peripheral_reset_line_n)
  );

  wire periph_reset = ~peripheral_reset_line_n;

  // The variant strap is caught while the peripheral reset is active.
  logic reduced_map;

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      reduced_map <= 1'b0;
    else if (periph_reset)
      reduced_map <= reduced_map_pin;
  end

  // --------------------------------------------------------------------
  // Bus access
  // --------------------------------------------------------------------
  wire           wr_cycle = io_strobe & io_write;
  wire           rd_cycle = io_strobe & io_read;
  wire [N-1:0]   wr_hit   = prrm_decode(io_addr, reduced_map) & {N{wr_cycle}};
  wire [N-1:0]   rd_hit   = prrm_decode(io_addr, reduced_map) & {N{rd_cycle}};

  // Pin-derived bits are sampled only while the peripheral reset is on.
  wire [15:0] pms_rst_value = `PRRM_RST_PMS |
    (16'(boot_memory_select) << `PRRM_PMS_BOOT_BIT) |
    (16'(external_level_bit) << `PRRM_PMS_LEVEL_BIT);
  wire [15:0] pinstat_rst_value = `PRRM_RST_PINSTAT |
    (16'(aux_pin_in) << `PRRM_PINSTAT_PIN_LSB);

  // --------------------------------------------------------------------
  // Register bank
  // --------------------------------------------------------------------
  logic [15:0] regq      [N];
  wire  [15:0] rst_value [N];
  wire  [15:0] rd_chain  [N+1];

  assign rd_chain[0] = 16'h0000;

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_reg
      if (g == I_PMS)
      begin : g_pms
        assign rst_value[g] = pms_rst_value;
      end
      else if (g == I_PINSTAT)
      begin : g_pin
        assign rst_value[g] = pinstat_rst_value;
      end
      else
      begin : g_const
        assign rst_value[g] = RST_TAB[g];
      end

      // Each register except the two serial data registers takes its reset value, then waits for a write.
      prrm_reg16 #(
        .RESET_CONST (RST_TAB[g]),
        .WRITE_MASK  (WMASK_TAB[g]),
        .HAS_RESET   (HAS_RST[g])
      ) u_reg (
        .clk         (clk),
        .rst_n       (rst_sync_n),
        .load_reset  (periph_reset),
        .reset_value (rst_value[g]),
        .write_en    (wr_hit[g]),
        .write_data  (io_wdata),
        .q           (regq[g])
      );

      assign rd_chain[g+1] = rd_chain[g] | (rd_hit[g] ? regq[g] : 16'h0000);
    end
  endgenerate

  // Unmapped addresses read as zero but are still acknowledged.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      io_rdata <= 16'h0000;
      io_ack   <= 1'b0;
    end
    else
    begin
      if (rd_cycle)
        io_rdata <= rd_chain[N];
      io_ack <= rd_cycle | wr_cycle;
    end
  end

  // --------------------------------------------------------------------
  // Pin controls
  // --------------------------------------------------------------------
  wire [3:0] aux_dir = regq[I_ASCTL][`PRRM_ASCTL_DIR_LSB +: 4];

  // The async port itself lies outside this block, so its line idles high.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      async_tx_out <= 1'b1;
      aux_pin_oe_n <= 4'hf;
      aux_pin_out  <= 4'h0;
    end
    else
    begin
      async_tx_out <= 1'b1;
      aux_pin_oe_n <= periph_reset ? 4'hf : ~aux_dir;
      aux_pin_out  <= 4'h0;
    end
  end

  assign core_clock_output_off    = regq[I_CLKPIN][`PRRM_CLKPIN_OFF_BIT];
  assign sync_serial_control      = regq[I_SSCTL];
  assign sync_serial_status       = regq[I_SSSTAT];
  assign sync_serial_multichannel = regq[I_SSMC];
  assign async_serial_control     = regq[I_ASCTL];
  assign baud_divisor             = regq[I_BAUD];
  assign countdown_control        = regq[I_CDCTL];
  assign reload_period            = regq[I_PERIOD];
  assign down_counter_value       = regq[I_COUNT];
  assign wait_state_control       = regq[I_WAIT];

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  // The first reset edge finds the bank still held in its async reset.
  pms_reset_a: assert property (
    rst_sync_n && periph_reset |=> regq[I_PMS] ==
      {12'h000, 2'b11, $past(external_level_bit), $past(boot_memory_select)})
    else $error("memory status reset value wrong");

  clk_pin_reset_a: assert property (
    periph_reset |=> !core_clock_output_off && regq[I_CLKPIN] == 16'h0000)
    else $error("clock pin control not cleared by reset");

  data_write_a: assert property (
    wr_hit[I_SSDATA] && !periph_reset |=> regq[I_SSDATA] == $past(io_wdata))
    else $error("sync data register lost a write");

  ssctl_reset_a: assert property (
    periph_reset |=> sync_serial_control == 16'h0030)
    else $error("sync control reset value wrong");

  ssctl_fields_a: assert property (
    periph_reset ##1 !periph_reset && !wr_hit[I_SSCTL]
      |=> sync_serial_control[5:4] == 2'b11)
    else $error("sync enables not held after reset");

  ssstat_reset_a: assert property (
    periph_reset |=> sync_serial_status == 16'h0000)
    else $error("sync status reset value wrong");

  ssmc_reset_a: assert property (
    periph_reset |=> sync_serial_multichannel == 16'h0000)
    else $error("sync multichannel reset value wrong");

  asctl_reset_a: assert property (
    periph_reset |=> async_serial_control == 16'h0000)
    else $error("async control reset value wrong");

  aux_input_a: assert property (
    periph_reset |=> aux_pin_oe_n == 4'hf && async_tx_out)
    else $error("aux pins or transmit pin wrong in reset");

  pinstat_reset_a: assert property (
    rst_sync_n && periph_reset
      |=> regq[I_PINSTAT] == {8'h18, 4'h0, $past(aux_pin_in)})
    else $error("pin status reset value wrong");

  baud_reset_a: assert property (
    periph_reset |=> baud_divisor == 16'h0001)
    else $error("baud divisor reset value wrong");

  cdctl_reset_a: assert property (
    periph_reset |=> countdown_control == 16'h0000)
    else $error("countdown control reset value wrong");

  period_reset_a: assert property (
    periph_reset |=> reload_period == 16'hffff)
    else $error("reload period reset value wrong");

  count_reset_a: assert property (
    periph_reset |=> down_counter_value == 16'hffff)
    else $error("counter reset value wrong");

  sscnt_reset_a: assert property (
    periph_reset |=> regq[I_SSCNT] == 16'h0000)
    else $error("sync counter reset value wrong");

  wait_reset_a: assert property (
    periph_reset |=> wait_state_control == 16'h0fff)
    else $error("wait-state reset value wrong");

  reduced_map_a: assert property (
    reduced_map && rd_cycle && io_addr == 16'hffff
      |=> io_rdata == $past(wait_state_control))
    else $error("reduced map wait-state read wrong");

  reduced_hole_a: assert property (
    reduced_map && rd_cycle && io_addr == 16'hfff7 |=> io_rdata == 16'h0000)
    else $error("reduced map decoded an absent register");

  hold_value_a: assert property (
    !periph_reset && !wr_hit[I_PERIOD] |=> $stable(reload_period))
    else $error("period changed without a write");

  ack_cycle_a: assert property (
    !io_strobe |=> !io_ack)
    else $error("answer without an I/O cycle");

endmodule : prrm_top
`default_nettype wire

// [prrm_cpu_model.sv]
`timescale 1ns/10ps
`default_nettype none
module prrm_cpu_model (
  input  wire logic        clk,       // core clock
  output var  logic        io_strobe, // I/O-space cycle
  output var  logic        io_write,  // write cycle
  output var  logic        io_read,   // read cycle
  output var  logic [15:0] io_addr,   // I/O address
  output var  logic [15:0] io_wdata,  // write data
  input  wire logic [15:0] io_rdata,  // read data
  input  wire logic        io_ack     // cycle answered
);
  initial
  begin
    io_strobe = 1'b0;
    io_write  = 1'b0;
    io_read   = 1'b0;
    io_addr   = 16'h0000;
    io_wdata  = 16'h0000;
  end

  // One I/O-space cycle. Between cycles the idle bus shows the inverse of
  // the last address and data, so a stale value never looks valid.
  task automatic xfer(input logic wr, input logic [15:0] a,
                      input logic [15:0] d, output logic [15:0] q,
                      output logic ok);
    @(negedge clk);
    io_strobe = 1'b1;
    io_write  = wr;
    io_read   = ~wr;
    io_addr   = a;
    io_wdata  = d;
    @(posedge clk);
    @(negedge clk);
    ok        = io_ack;
    q         = io_rdata;
    io_strobe = 1'b0;
    io_write  = 1'b0;
    io_read   = 1'b0;
    io_addr   = ~a;
    io_wdata  = ~d;
  endtask : xfer
endmodule : prrm_cpu_model
`default_nettype wire

// [test_peripheral_register_reset_map.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHECK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module test_peripheral_register_reset_map;
  logic        clk;
  logic        reset_n;
  logic        soft_reset_req;
  logic        reduced_map_pin;
  logic        boot_memory_select;
  logic        external_level_bit;
  logic [3:0]  aux_pin_in;
  logic        io_strobe;
  logic        io_write;
  logic        io_read;
  logic [15:0] io_addr;
  logic [15:0] io_wdata;
  logic [15:0] io_rdata;
  logic        io_ack;
  logic        peripheral_reset_line_n;
  logic        core_clock_output_off;
  logic        async_tx_out;
  logic [3:0]  aux_pin_oe_n;
  logic [3:0]  aux_pin_out;
  int          n_fail;
  int          n_tests;

  prrm_top uut (.clk(clk), .reset_n(reset_n),
    .soft_reset_req(soft_reset_req), .reduced_map_pin(reduced_map_pin),
    .boot_memory_select(boot_memory_select),
    .external_level_bit(external_level_bit), .aux_pin_in(aux_pin_in),
    .io_strobe(io_strobe), .io_write(io_write), .io_read(io_read),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_ack(io_ack), .peripheral_reset_line_n(peripheral_reset_line_n),
    .core_clock_output_off(core_clock_output_off),
    .async_tx_out(async_tx_out), .aux_pin_out(aux_pin_out),
    .aux_pin_oe_n(aux_pin_oe_n), .sync_serial_control(),
    .sync_serial_status(), .sync_serial_multichannel(),
    .async_serial_control(), .baud_divisor(), .countdown_control(),
    .reload_period(), .down_counter_value(), .wait_state_control());

  prrm_cpu_model cpu (.clk(clk), .io_strobe(io_strobe),
    .io_write(io_write), .io_read(io_read), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic        ok;
    cpu.xfer(1'b1, a, d, q, ok);
    `CHECK(ok, 1'b1)
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] q;
    logic        ok;
    cpu.xfer(1'b0, a, 16'h0000, q, ok);
    `CHECK(ok, 1'b1)
    `CHECK(q, e)
  endtask : rd

  task automatic hard_reset;
    @(negedge clk);
    reset_n = 1'b0;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (5) @(negedge clk);
  endtask : hard_reset

  // A line that never moves would hang the run, so the wait is bounded.
  task automatic wait_line(input logic v);
    int k;
    k = 0;
    while (peripheral_reset_line_n !== v && k < 16)
    begin
      @(negedge clk);
      k++;
    end
    if (k == 16)
    begin
      n_fail++;
      $display("unexpected at %0t: reset line stuck", $time);
      tally_and_finish();
    end
  endtask : wait_line

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic check_reset_values;
    rd(16'hffe4, 16'h000d);
    rd(16'hffe8, 16'h0000);
    rd(16'hfff1, 16'h0030);
    rd(16'hfff2, 16'h0000);
    rd(16'hfff3, 16'h0000);
    rd(16'hfff5, 16'h0000);
    rd(16'hfff6, 16'h180a);
    rd(16'hfff7, 16'h0001);
    rd(16'hfff8, 16'h0000);
    rd(16'hfff9, 16'hffff);
    rd(16'hfffa, 16'hffff);
    rd(16'hfffb, 16'h0000);
    rd(16'hfffc, 16'h0fff);
    `CHECK(async_tx_out, 1'b1)
    `CHECK(aux_pin_oe_n, 4'hf)
    `CHECK(aux_pin_out, 4'h0)
    `CHECK(core_clock_output_off, 1'b0)
  endtask : check_reset_values

  task automatic write_and_access;
    wr(16'hfff9, 16'h1234);
    rd(16'hfff9, 16'h1234);
    wr(16'hfff0, 16'h5a5a);
    wr(16'hfff4, 16'ha5a5);
    rd(16'hfff0, 16'h5a5a);
    rd(16'hfff4, 16'ha5a5);
    wr(16'hffe4, 16'h0000);
    rd(16'hffe4, 16'h0001);
    wr(16'hffe8, 16'hffff);
    rd(16'hffe8, 16'h0001);
    `CHECK(core_clock_output_off, 1'b1)
    wr(16'hfff6, 16'hffff);
    rd(16'hfff6, 16'hff0a);
    wr(16'hfff5, 16'h0500);
    wr(16'hffe0, 16'hffff);
    rd(16'hffe0, 16'h0000);
    `CHECK(aux_pin_oe_n, 4'ha)
  endtask : write_and_access

  // New pin levels must be captured by the peripheral reset.
  task automatic soft_reset_reload;
    aux_pin_in = 4'h3;
    @(negedge clk);
    soft_reset_req = 1'b1;
    @(negedge clk);
    soft_reset_req = 1'b0;
    wait_line(1'b0);
    `CHECK(peripheral_reset_line_n, 1'b0)
    wait_line(1'b1);
    rd(16'hfff9, 16'hffff);
    rd(16'hffe8, 16'h0000);
    rd(16'hfff6, 16'h1803);
    `CHECK(aux_pin_oe_n, 4'hf)
  endtask : soft_reset_reload

  task automatic reduced_map_decode;
    reduced_map_pin = 1'b1;
    hard_reset();
    rd(16'hfffc, 16'h0000);
    rd(16'hfffd, 16'hffff);
    rd(16'hfffe, 16'hffff);
    rd(16'hffff, 16'h0fff);
    rd(16'hfff1, 16'h0000);
    wr(16'hfffd, 16'h4321);
    rd(16'hfffd, 16'h4321);
  endtask : reduced_map_decode

  initial
  begin
    reset_n            = 1'b1;
    soft_reset_req     = 1'b0;
    reduced_map_pin    = 1'b0;
    boot_memory_select = 1'b1;
    external_level_bit = 1'b0;
    aux_pin_in         = 4'ha;
    n_fail             = 0;
    n_tests            = 0;
    hard_reset();
    check_reset_values();
    write_and_access();
    soft_reset_reload();
    reduced_map_decode();
    tally_and_finish();
  end
endmodule : test_peripheral_register_reset_map
`default_nettype wire
